// ### shared/dhpg_pkg.sv
/*
 Constants for the display hot-plug output guard.
 Assumes one 200 MHz clock and an AHB-Lite register bus.
*/
package dhpg_pkg;
  // Clock and filter timing
  localparam int CLK_PS      = 5000;
  localparam int DEB_NS      = 1000;
  localparam int DEB_CYC     = (DEB_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DEB_W       = 8;
  localparam logic [DEB_W-1:0] DEB_MAX = DEB_W'(DEB_CYC - 1);

  // Identity read addresses on the control channel
  localparam logic [7:0] ID_ADDR_PRI = 8'ha2;
  localparam logic [7:0] ID_ADDR_SEC = 8'ha0;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ  = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;

  // Control fields
  localparam int CTRL_RESTART = 0;

  // Interrupt status fields
  localparam int IRQ_W      = 3;
  localparam int IRQ_CONN   = 0;
  localparam int IRQ_DISC   = 1;
  localparam int IRQ_IDDONE = 2;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  // Status fields
  localparam int ST_STATE = 0;
  localparam int ST_DIG   = 3;
  localparam int ST_TX    = 4;
  localparam int ST_DAC   = 5;
  localparam int ST_SENSE = 6;

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACT = 1;

  typedef enum logic [2:0] {
    S_PRI   = 3'b000,
    S_SEC   = 3'b001,
    S_DIG   = 3'b010,
    S_DLOST = 3'b011,
    S_ANA   = 3'b100,
    S_ALOST = 3'b101,
    S_HOLD  = 3'b110
  } dhpg_state_e;
endpackage

// ### core/dhpg_guard.sv
/*
 Hot-plug output guard: watches the charge-power comparator flag,
 picks digital or analogue output from the monitor identity data,
 gates both outputs and flags connect events.
 Assumes an external control-channel reader on the same clock and a
 comparator flag asynchronous to the clock.
*/
`timescale 1ns/10ps

// Functional notes
// - Sense below threshold always drops the digital transmitter enable.
// - That disable is pure hardware; software plays no part.
// - After reset, read identity at A2h before any output enable.
// - Identity interface type chooses digital or analogue path.
// - Digital transmitter enabled only while sense is above threshold.
// - Sense returning after loss leaves the transmitter off.
// - Sense returning after loss raises a connect interrupt.
// - Analogue path enables the converters after identification.
// - In analogue mode a sense loss keeps converters running.
// - Analogue mode: on sense return, disable converters, then signal.
// - No identity at A2h: retry at A0h and treat as analogue.
module dhpg_guard
  import dhpg_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Charge-power comparator flag, asynchronous
  input  wire logic        sense_raw,
  // Identity reader handshake
  output logic             id_req,
  output logic [7:0]       id_addr,
  input  wire logic        id_done,
  input  wire logic        id_ok,
  input  wire logic        id_digital,
  // Output gates and interrupt
  output logic             tx_en,
  output logic             dac_en,
  output logic             irq
);

  dhpg_state_e         state;
  logic                sync_a;
  logic                sync_b;
  logic                sense_f;
  logic                sense_d;
  logic [DEB_W-1:0]    deb_cnt;
  logic                rise;
  logic                fall;
  logic                id_busy;
  logic                restart;
  logic                wr_pend;
  logic [7:0]          wr_addr;
  logic                rd_irq;
  logic [IRQ_W-1:0]    irq_stat;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    irq_set;
  logic                addr_ok;
  logic                id_fin;
  logic [31:0]         next_rdata;
  logic [IRQ_W-1:0]    next_stat;

  // Active AHB transfer in its address phase
  function automatic logic ahb_act(input logic s, input logic [1:0] t,
                                   input logic r);
    return s & t[HTRANS_ACT] & r;
  endfunction

  // State groups used by the event decode. A state left out of both
  // groups, as S_PRI, S_SEC and S_HOLD are, raises no connect or
  // disconnect event.
  // States in which a display is believed attached and driven
  function automatic logic path_live(input dhpg_state_e s);
    return (s == S_DIG) | (s == S_ANA);
  endfunction

  // States waiting for the sense line to come back
  function automatic logic path_lost(input dhpg_state_e s);
    return (s == S_DLOST) | (s == S_ALOST);
  endfunction

  // Two-flop synchroniser; only sync_b is looked at
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= sense_raw;
      sync_b <= sync_a;
    end
  end

  // Debounce: level must hold for the whole window to be believed.
  // Costs about a microsecond of latency, which the cable can afford.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      deb_cnt <= '0;
      sense_f <= 1'b0;
    end else if (sync_b == sense_f) begin
      deb_cnt <= '0;
    end else if (deb_cnt == DEB_MAX) begin
      deb_cnt <= '0;
      sense_f <= sync_b;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  // Edge history of the filtered level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sense_d <= 1'b0;
    end else begin
      sense_d <= sense_f;
    end
  end

  assign rise = sense_f & ~sense_d;
  assign fall = ~sense_f & sense_d;
  assign id_fin = id_busy & id_done;

  // Identity read requests: one pulse per read, busy until done
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      id_req  <= 1'b0;
      id_addr <= ID_ADDR_PRI;
      id_busy <= 1'b0;
    end else begin
      id_req <= 1'b0;
      if (id_fin) begin
        id_busy <= 1'b0;
      end else if (!id_busy && !id_req && state == S_PRI) begin
        id_req  <= 1'b1;
        id_addr <= ID_ADDR_PRI;
        id_busy <= 1'b1;
      end else if (!id_busy && !id_req && state == S_SEC) begin
        id_req  <= 1'b1;
        id_addr <= ID_ADDR_SEC;
        id_busy <= 1'b1;
      end
    end
  end

  // Path sequencer. Outputs stay off until identification ends, and a
  // sense return in S_DLOST or S_ALOST lands in S_HOLD so a new monitor
  // is not driven with settings meant for the old one.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_PRI;
    end else begin
      unique case (state)
        S_PRI: begin
          if (id_fin && id_ok && id_digital) begin
            state <= sense_f ? S_DIG : S_DLOST;
          end else if (id_fin && id_ok) begin
            state <= S_ANA;
          end else if (id_fin) begin
            state <= S_SEC;
          end
        end
        S_SEC: begin
          if (id_fin) begin
            state <= S_ANA;
          end
        end
        S_DIG: begin
          if (!sense_f) begin
            state <= S_DLOST;
          end
        end
        S_DLOST: begin
          if (rise) begin
            state <= S_HOLD;
          end
        end
        S_ANA: begin
          if (fall) begin
            state <= S_ALOST;
          end
        end
        S_ALOST: begin
          if (rise) begin
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (restart) begin
            state <= S_PRI;
          end
        end
        default: begin
          state <= S_HOLD;
        end
      endcase
    end
  end

  // Digital transmitter gate. The sense term is raw hardware and
  // overrides everything, so a hung CPU cannot keep it on.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_en <= 1'b0;
    end else if (!sense_f) begin
      tx_en <= 1'b0;
    end else if (state == S_PRI && id_fin && id_ok && id_digital) begin
      tx_en <= 1'b1;
    end else if (state != S_DIG) begin
      tx_en <= 1'b0;
    end
  end

  // Analogue converter gate; a sense loss alone never turns it off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dac_en <= 1'b0;
    end else if (state == S_ALOST && rise) begin
      dac_en <= 1'b0;
    end else if (state == S_PRI && id_fin && id_ok && !id_digital) begin
      dac_en <= 1'b1;
    end else if (state == S_SEC && id_fin) begin
      dac_en <= 1'b1;
    end else if (state != S_ANA && state != S_ALOST) begin
      dac_en <= 1'b0;
    end
  end

  // Hardware events feeding the sticky status
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CONN] = rise & path_lost(state);
    irq_set[IRQ_DISC] = fall & path_live(state);
    irq_set[IRQ_IDDONE] = id_fin & ((state == S_ANA) | (state == S_SEC)
                        | (state == S_PRI & id_ok));
  end

  // Bus decode of the address phase
  assign addr_ok = ahb_act(hsel, htrans, hready);

  // Read-to-clear strobe, taken in the address phase: the value sampled
  // into hrdata and the bits cleared are then the same snapshot, so an
  // event landing on the read edge is never cleared unseen.
  assign rd_irq = addr_ok & ~hwrite & (haddr[7:0] == OFF_IRQ);

  // Next sticky status; a new event wins over the read that clears it
  assign next_stat = (irq_stat & ~{IRQ_W{rd_irq}}) | irq_set;

  // Sticky status
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_stat;
    end
  end

  // Interrupt line sees a new event a cycle after the gate has already
  // switched, so the outputs are off before software hears of the
  // connection; a read clear drops it at once.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & ~{IRQ_W{rd_irq}} & irq_mask);
    end
  end

  // Write path: capture in address phase, apply in data phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Mask register and restart strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= MASK_RST;
      restart  <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (wr_pend && wr_addr == OFF_MASK) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
      if (wr_pend && wr_addr == OFF_CTRL) begin
        restart <= hwdata[CTRL_RESTART];
      end
    end
  end

  // Read mux, evaluated in the address phase
  always_comb begin
    next_rdata = '0;
    unique case (haddr[7:0])
      OFF_STAT: begin
        next_rdata[ST_STATE +: $bits(dhpg_state_e)] = state;
        next_rdata[ST_DIG]   = (state == S_DIG) | (state == S_DLOST);
        next_rdata[ST_TX]    = tx_en;
        next_rdata[ST_DAC]   = dac_en;
        next_rdata[ST_SENSE] = sense_f;
      end
      OFF_IRQ: next_rdata[IRQ_W-1:0] = irq_stat;
      OFF_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = '0;
    endcase
  end

  // Read data, captured in the address phase and held for the data phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata <= '0;
    end else begin
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// ### sim/dhpg_chk.sv
/*
 Port checker for the hot-plug output guard.
 Assumes it is bound to dhpg_guard and sees only its ports.
*/
`timescale 1ns/10ps
module dhpg_chk
  import dhpg_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Sense flag and identity handshake
  input wire logic       sense_raw,
  input wire logic       id_req,
  input wire logic [7:0] id_addr,
  input wire logic       id_done,
  input wire logic       id_ok,
  input wire logic       id_digital,
  // Output gates
  input wire logic       tx_en,
  input wire logic       dac_en
);
  logic [8:0] lo_n;
  logic [8:0] hi_n;
  logic       seen;

  // Raw run lengths; the filter may only act after about 200 of them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lo_n <= 9'h0;
      hi_n <= 9'h0;
    end else begin
      lo_n <= sense_raw ? 9'h0 : lo_n + {8'h0, ~&lo_n};
      hi_n <= sense_raw ? hi_n + {8'h0, ~&hi_n} : 9'h0;
    end
  end

  // Set by the first identity request after reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      seen <= 1'b0;
    else if (id_req)
      seen <= 1'b1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_tx_drop: assert property (lo_n >= 9'h0d2 |-> !tx_en)
    else $error("tx on after long sense loss");
  chk_glitch_free: assert property ($fell(tx_en) |-> lo_n >= 9'h0c6)
    else $error("tx dropped on short glitch");
  chk_dac_hold: assert property ($fell(dac_en) |-> hi_n >= 9'h0c6)
    else $error("dac dropped without sense return");
  chk_tx_cause: assert property ($rose(tx_en) |->
    $past(id_done & id_ok & id_digital) && hi_n >= 9'h0c6)
    else $error("tx on without digital identity");
  chk_dac_cause: assert property ($rose(dac_en) |-> $past(id_done))
    else $error("dac on without identity");
  chk_id_first: assert property ((tx_en | dac_en) |-> seen)
    else $error("output before identity read");
  chk_pri_addr: assert property (id_req & !seen |-> id_addr == ID_ADDR_PRI)
    else $error("first read not at primary");
  chk_sec_retry: assert property (id_done & !id_ok & id_addr == ID_ADDR_PRI
    |-> ##[1:4] (id_req & id_addr == ID_ADDR_SEC))
    else $error("no retry at secondary");
endmodule

bind dhpg_guard dhpg_chk u_chk (
  .clock      (clock),
  .resetn     (resetn),
  .sense_raw  (sense_raw),
  .id_req     (id_req),
  .id_addr    (id_addr),
  .id_done    (id_done),
  .id_ok      (id_ok),
  .id_digital (id_digital),
  .tx_en      (tx_en),
  .dac_en     (dac_en)
);

// ### sim/dhpg_mon.sv
/*
 Monitor-side model that answers identity reads after a set lag.
 Assumes the guard's clock; the bench sets lag and answers.
*/
`timescale 1ns/10ps
module dhpg_mon
  import dhpg_pkg::*;
(
  // Guard side
  input  wire logic       clock,
  input  wire logic       id_req,
  input  wire logic [7:0] id_addr,
  output logic            id_done,
  output logic            id_ok,
  output logic            id_digital,
  // Bench control
  input  wire logic       ok_pri,
  input  wire logic       dig,
  input  wire logic [7:0] lag
);
  logic [7:0] cnt  = 8'h0;
  logic       busy = 1'b0;
  logic       pri  = 1'b0;
  logic       junk = 1'b0;

  // Answers stand only with id_done; between them a changing pattern
  always @(posedge clock) begin
    junk <= ~junk;
    id_done <= 1'b0;
    id_ok <= junk;
    id_digital <= ~junk;
    if (id_req) begin
      busy <= 1'b1;
      cnt <= lag;
      pri <= (id_addr == ID_ADDR_PRI);
    end else if (busy && cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
    end else if (busy) begin
      busy <= 1'b0;
      id_done <= 1'b1;
      id_ok <= pri ? ok_pri : 1'b1;
      id_digital <= dig;
    end
  end
endmodule

// ### sim/dhpg_guard_tb.sv
/*
 Bench for the hot-plug guard: bus tasks and hot-plug sequences.
 Assumes the checker is bound and the monitor model answers reads.
*/
`timescale 1ns/10ps
module dhpg_guard_tb;
  import dhpg_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        sense_raw = 1'b1;
  logic        ok_pri = 1'b1;
  logic        dig = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  lag = 8'hfa;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r;
  wire logic        hreadyout, hresp, id_req, id_done, id_ok, id_digital;
  wire logic        tx_en, dac_en, irq;
  wire logic [7:0]  id_addr;
  wire logic [31:0] hrdata;
  int err_total = 0;
  int total_checks = 0;

  dhpg_guard u_dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sense_raw(sense_raw), .id_req(id_req), .id_addr(id_addr), .id_done(id_done),
    .id_ok(id_ok), .id_digital(id_digital), .tx_en(tx_en), .dac_en(dac_en), .irq(irq));
  dhpg_mon u_mon (.clock(clock), .id_req(id_req), .id_addr(id_addr), .id_done(id_done),
    .id_ok(id_ok), .id_digital(id_digital), .ok_pri(ok_pri), .dig(dig), .lag(lag));

  initial forever #2.5 clock = ~clock;

  // One single-word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
    ck(32'(hresp), 32'h0);
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Level change held well past the 200-cycle filter
  task automatic sense(input logic v);
    @(posedge clock);
    sense_raw <= v;
    repeat (260) @(posedge clock);
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    ck(32'({tx_en, dac_en, irq}), 32'h0);
    ck(32'(id_addr), 32'(ID_ADDR_PRI));
    resetn <= 1'b1;
    bus(1'b0, OFF_MASK, 32'h0);
    ck(r, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    ck(r, 32'h0);
    bus(1'b1, OFF_MASK, 32'h7);
    bus(1'b0, OFF_MASK, 32'h0);
    ck(r, 32'h7);
    repeat (300) @(posedge clock);
    ck(32'(tx_en), 32'h1);
    bus(1'b0, OFF_STAT, 32'h0);
    ck(r & 32'h37, 32'h12);
    ck(32'(irq), 32'h1);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h4);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h0);
    repeat (2) @(negedge clock);
    ck(32'(irq), 32'h0);
    // Short dip must be filtered out
    @(posedge clock);
    sense_raw <= 1'b0;
    repeat (50) @(posedge clock);
    sense_raw <= 1'b1;
    repeat (260) @(posedge clock);
    ck(32'(tx_en), 32'h1);
    sense(1'b0);
    ck(32'(tx_en), 32'h0);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h2);
    bus(1'b0, OFF_STAT, 32'h0);
    ck(r & 32'h37, 32'h03);
    sense(1'b1);
    ck(32'(tx_en), 32'h0);
    ck(32'(irq), 32'h1);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h1);
    bus(1'b0, OFF_STAT, 32'h0);
    ck(r & 32'h37, 32'h06);
    // Software reruns identification; an analogue monitor this time
    dig <= 1'b0;
    lag <= 8'h14;
    bus(1'b1, OFF_CTRL, 32'h1);
    repeat (60) @(posedge clock);
    ck(32'({tx_en, dac_en}), 32'h1);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h4);
    sense(1'b0);
    ck(32'(dac_en), 32'h1);
    bus(1'b0, OFF_STAT, 32'h0);
    ck(r & 32'h37, 32'h25);
    sense(1'b1);
    ck(32'(dac_en), 32'h0);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h3);
    // Primary read fails; fallback is analogue despite a digital answer
    ok_pri <= 1'b0;
    dig <= 1'b1;
    bus(1'b1, OFF_MASK, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    repeat (80) @(negedge clock);
    ck(32'({tx_en, dac_en}), 32'h1);
    ck(32'(irq), 32'h0);
    bus(1'b1, OFF_MASK, 32'h4);
    repeat (2) @(negedge clock);
    ck(32'(irq), 32'h1);
    bus(1'b0, OFF_IRQ, 32'h0);
    ck(r, 32'h4);
    repeat (2) @(negedge clock);
    ck(32'(irq), 32'h0);
    tally_and_finish;
  end

  // Whole sequence needs about 1900 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end
endmodule
